// ---- pig_port_cfg.sv ----
//
// Purpose: Port A digital input gating, USB pin claims and pin interrupt configuration for ports A and B
// Assumes: Pin and output data inputs synchronous to ref_clk
// Notes: APB answers after one wait-free access phase; unmapped addresses raise pslverr
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

module pig_port_cfg (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] pa_pin_in,
	input wire logic [23:0] pb_pin_in,
	input wire logic [15:0] pa_out_data,
	input wire logic [23:0] pb_out_data,
	input wire logic [15:0] pa_dir_out,
	input wire logic [23:0] pb_dir_out,
	input wire logic usb1_ctrl_pullup_enable,
	input wire logic usb2_ctrl_pullup_enable,
	output logic [15:0] pa_din,
	output logic first_usb_pin_claim,
	output logic second_usb_pin_claim,
	output logic usb1_dplus_pullup,
	output logic usb2_dplus_pullup,
	output logic pa_irq_req,
	output logic pb_irq_req
);

	// ****************************************
	// Port A input block mask
	// ****************************************
	function automatic logic [15:0] pig_pa_block(input logic [15:0] g);
		logic [15:0] m;
		m = 16'h0000;
		// [RULE_01] Pins 14 and 15
		m[15:14] = {2{g[pig_pkg::PIG_BIT_CH4_5]}};
		// [RULE_02] Pins 12 and 13
		m[13:12] = {2{g[pig_pkg::PIG_BIT_CH2_3]}};
		// [RULE_03] Slow crystal pins
		m[11:10] = {2{g[pig_pkg::PIG_BIT_SLOW_XTAL]}};
		// [RULE_04] Pin 9
		m[9] = g[pig_pkg::PIG_BIT_CH13];
		// [RULE_05] Pin 8
		m[8] = g[pig_pkg::PIG_BIT_CH12];
		// [RULE_08] Pin 7
		m[7] = g[pig_pkg::PIG_BIT_CH11];
		// [RULE_09] Pin 6
		m[6] = g[pig_pkg::PIG_BIT_CH10];
		// [RULE_06] Pin 5
		m[5] = g[pig_pkg::PIG_BIT_CH1];
		// [RULE_07] Pin 4
		m[4] = g[pig_pkg::PIG_BIT_CH0];
		// [RULE_10] Pins 2 and 3
		m[3:2] = {2{g[pig_pkg::PIG_BIT_CH6_7]}};
		// [RULE_11] Pins 0 and 1
		m[1:0] = {2{g[pig_pkg::PIG_BIT_CH8_9]}};
		return m;
	endfunction

	// Maps a 24-bit port B vector onto its 16 interrupt slots
	function automatic logic [15:0] pig_pb_slots(input logic [23:0] v, input logic remap);
		logic [15:0] s;
		s = v[15:0];
		// [RULE_21] Slots 9:8 remap
		if (remap) begin
			s[9:8] = v[23:22];
		end
		return s;
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] gating_r;
	pig_pkg::pig_irq_cfg_s pa_cfg_r;
	pig_pkg::pig_irq_cfg_s pb_cfg_r;
	logic [15:0] pa_pend_r;
	logic [15:0] pb_pend_r;
	logic remap_r;
	logic [15:0] pa_act_prev_r;
	logic [15:0] pb_act_prev_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [15:0] pa_din_r;
	logic usb1_claim_r;
	logic usb2_claim_r;
	logic usb1_pu_r;
	logic usb2_pu_r;
	logic pa_irq_r;
	logic pb_irq_r;

	logic wr_acc;
	logic setup;
	logic mapped;
	logic [31:0] rd_word;
	logic [15:0] pa_block;
	logic [15:0] pa_act;
	logic [15:0] pb_act;
	logic [15:0] pa_set;
	logic [15:0] pb_set;
	logic [15:0] pa_clr;
	logic [15:0] pb_clr;
	logic [15:0] pb_in_slot;
	logic [15:0] pb_pol_slot;
	logic [15:0] pb_dir_slot;

	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready_r & pwrite;
	assign pa_block = pig_pa_block(gating_r);

	// ****************************************
	// APB read decode
	// ****************************************
	always_comb begin
		mapped = 1'b1;
		rd_word = pig_pkg::PIG_RST_WORD;
		case (paddr)
			pig_pkg::PIG_OFS_GATING: rd_word[15:0] = gating_r;
			pig_pkg::PIG_OFS_PA_EN: rd_word[15:0] = pa_cfg_r.enable;
			pig_pkg::PIG_OFS_PB_EN: rd_word[15:0] = pb_cfg_r.enable;
			pig_pkg::PIG_OFS_PA_MODE: rd_word[15:0] = pa_cfg_r.edge_mode;
			pig_pkg::PIG_OFS_PB_MODE: rd_word[15:0] = pb_cfg_r.edge_mode;
			pig_pkg::PIG_OFS_PA_PEND: rd_word[15:0] = pa_pend_r;
			pig_pkg::PIG_OFS_PB_PEND: rd_word[15:0] = pb_pend_r;
			pig_pkg::PIG_OFS_CTRL: rd_word[pig_pkg::PIG_BIT_REMAP] = remap_r;
			default: mapped = 1'b0;
		endcase
	end

	// ****************************************
	// APB answer
	// ****************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= pig_pkg::PIG_RST_WORD;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup & ~mapped;
			if (setup & ~pwrite & mapped) begin
				prdata_r <= rd_word;
			end else if (setup) begin
				prdata_r <= pig_pkg::PIG_RST_WORD;
			end
		end
	end

	// ****************************************
	// Configuration writes
	// ****************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			gating_r <= pig_pkg::PIG_RST_REG16;
			pa_cfg_r <= {pig_pkg::PIG_RST_REG16, pig_pkg::PIG_RST_REG16};
			pb_cfg_r <= {pig_pkg::PIG_RST_REG16, pig_pkg::PIG_RST_REG16};
			remap_r <= 1'b0;
		end else if (wr_acc) begin
			case (paddr)
				pig_pkg::PIG_OFS_GATING: gating_r <= pwdata[15:0];
				// [RULE_17] Port A enables
				pig_pkg::PIG_OFS_PA_EN: pa_cfg_r.enable <= pwdata[15:0];
				// [RULE_18] Port B enables
				pig_pkg::PIG_OFS_PB_EN: pb_cfg_r.enable <= pwdata[15:0];
				// [RULE_19] Port A modes
				pig_pkg::PIG_OFS_PA_MODE: pa_cfg_r.edge_mode <= pwdata[15:0];
				// [RULE_20] Port B modes
				pig_pkg::PIG_OFS_PB_MODE: pb_cfg_r.edge_mode <= pwdata[15:0];
				pig_pkg::PIG_OFS_CTRL: remap_r <= pwdata[pig_pkg::PIG_BIT_REMAP];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Trigger condition per slot
	// ****************************************
	assign pb_in_slot = pig_pb_slots(pb_pin_in, remap_r);
	assign pb_pol_slot = pig_pb_slots(pb_out_data, remap_r);
	assign pb_dir_slot = pig_pb_slots(pb_dir_out, remap_r);
	assign pa_clr = (wr_acc && paddr == pig_pkg::PIG_OFS_PA_PEND) ? pwdata[15:0] : 16'h0000;
	assign pb_clr = (wr_acc && paddr == pig_pkg::PIG_OFS_PB_PEND) ? pwdata[15:0] : 16'h0000;

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_slot
			// [RULE_22] Match level against polarity
			// [RULE_24] Blocked inputs never active
			assign pa_act[i] = ~pa_dir_out[i] & ~pa_block[i] & (pa_pin_in[i] == pa_out_data[i]);
			assign pb_act[i] = ~pb_dir_slot[i] & (pb_in_slot[i] == pb_pol_slot[i]);
			// [RULE_19] Edge or level on port A
			assign pa_set[i] = pa_cfg_r.enable[i] & pa_act[i] & (~pa_cfg_r.edge_mode[i] | ~pa_act_prev_r[i]);
			// [RULE_20] Edge or level on port B
			assign pb_set[i] = pb_cfg_r.enable[i] & pb_act[i] & (~pb_cfg_r.edge_mode[i] | ~pb_act_prev_r[i]);
		end
	endgenerate

	// ****************************************
	// Pending flags
	// ****************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pa_pend_r <= pig_pkg::PIG_RST_REG16;
			pb_pend_r <= pig_pkg::PIG_RST_REG16;
			pa_act_prev_r <= pig_pkg::PIG_RST_REG16;
			pb_act_prev_r <= pig_pkg::PIG_RST_REG16;
		end else begin
			// [RULE_23] Write one clears, set wins
			pa_pend_r <= (pa_pend_r & ~pa_clr) | pa_set;
			pb_pend_r <= (pb_pend_r & ~pb_clr) | pb_set;
			pa_act_prev_r <= pa_act;
			pb_act_prev_r <= pb_act;
		end
	end

	// ****************************************
	// Pin side outputs
	// ****************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pa_din_r <= 16'h0000;
			usb1_claim_r <= 1'b0;
			usb2_claim_r <= 1'b0;
			usb1_pu_r <= 1'b0;
			usb2_pu_r <= 1'b0;
			pa_irq_r <= 1'b0;
			pb_irq_r <= 1'b0;
		end else begin
			// [RULE_24] Blocked inputs read low
			pa_din_r <= pa_pin_in & ~pa_block;
			// [RULE_12] First USB pins
			usb1_claim_r <= gating_r[pig_pkg::PIG_BIT_USB1_CLAIM];
			// [RULE_14] Second USB pins
			usb2_claim_r <= gating_r[pig_pkg::PIG_BIT_USB2_CLAIM];
			// [RULE_13] First pull-up force
			usb1_pu_r <= gating_r[pig_pkg::PIG_BIT_USB1_PU] | usb1_ctrl_pullup_enable;
			// [RULE_15] Second pull-up force
			usb2_pu_r <= gating_r[pig_pkg::PIG_BIT_USB2_PU] | usb2_ctrl_pullup_enable;
			pa_irq_r <= |pa_pend_r;
			pb_irq_r <= |pb_pend_r;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pa_din = pa_din_r;
	assign first_usb_pin_claim = usb1_claim_r;
	assign second_usb_pin_claim = usb2_claim_r;
	assign usb1_dplus_pullup = usb1_pu_r;
	assign usb2_dplus_pullup = usb2_pu_r;
	assign pa_irq_req = pa_irq_r;
	assign pb_irq_req = pb_irq_r;

endmodule

// ---- pig_pkg.sv ----
//
// Purpose: Constants and types of the port pin input gate and interrupt configuration block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: 16-bit registers sit in the low half of each word
//
// Behaviour
// [RULE_01] Gating bit 15 set blocks digital input on port A pins 14 and 15
// [RULE_02] Gating bit 14 set blocks digital input on port A pins 12 and 13
// [RULE_03] Gating bit 13 set blocks slow crystal pins, port A 10 and 11
// [RULE_04] Gating bit 12 set blocks digital input on port A pin 9
// [RULE_05] Gating bit 11 set blocks digital input on port A pin 8
// [RULE_06] Gating bit 10 set blocks digital input on port A pin 5
// [RULE_07] Gating bit 9 set blocks digital input on port A pin 4
// [RULE_08] Gating bit 3 set blocks digital input on port A pin 7
// [RULE_09] Gating bit 2 set blocks digital input on port A pin 6
// [RULE_10] Gating bit 1 set blocks digital input on port A pins 2 and 3
// [RULE_11] Gating bit 0 set blocks digital input on port A pins 0 and 1
// [RULE_12] Gating bit 7 hands port B pins 10 and 11 to first USB transceiver
// [RULE_13] Gating bit 6 forces first USB D+ pull-up on, else controller enable rules
// [RULE_14] Gating bit 5 hands port B pins 12 and 13 to second USB transceiver
// [RULE_15] Gating bit 4 forces second USB D+ pull-up on, else controller enable rules
// [RULE_16] Software should block digital input on pins used for analog or touch sensing
// [RULE_17] Port A interrupt enable bits enable each pin interrupt, reset zero
// [RULE_18] Port B interrupt enable bits enable each pin interrupt, reset zero
// [RULE_19] Port A mode bits pick edge when 1, level when 0
// [RULE_20] Port B mode bits pick edge when 1, level when 0
// [RULE_21] Port B bits 9:8 follow pins 23:22 or 9:8 by remap select
// [RULE_22] Output data bit of input pin picks polarity: 1 high/rising, 0 low/falling
// [RULE_23] Pending flag reads 1 when interrupt pending, cleared by writing 1
// [RULE_24] Flag sets only when enabled and condition met; blocked input reads inactive
//
package pig_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] PIG_OFS_GATING = 8'h00;
	localparam logic [7:0] PIG_OFS_PA_EN = 8'h04;
	localparam logic [7:0] PIG_OFS_PB_EN = 8'h08;
	localparam logic [7:0] PIG_OFS_PA_MODE = 8'h0c;
	localparam logic [7:0] PIG_OFS_PB_MODE = 8'h10;
	localparam logic [7:0] PIG_OFS_PA_PEND = 8'h14;
	localparam logic [7:0] PIG_OFS_PB_PEND = 8'h18;
	localparam logic [7:0] PIG_OFS_CTRL = 8'h1c;

	// ****************************************
	// Field positions of the gating and control registers
	// ****************************************
	localparam int PIG_BIT_CH4_5 = 15;
	localparam int PIG_BIT_CH2_3 = 14;
	localparam int PIG_BIT_SLOW_XTAL = 13;
	localparam int PIG_BIT_CH13 = 12;
	localparam int PIG_BIT_CH12 = 11;
	localparam int PIG_BIT_CH1 = 10;
	localparam int PIG_BIT_CH0 = 9;
	localparam int PIG_BIT_USB1_CLAIM = 7;
	localparam int PIG_BIT_USB1_PU = 6;
	localparam int PIG_BIT_USB2_CLAIM = 5;
	localparam int PIG_BIT_USB2_PU = 4;
	localparam int PIG_BIT_CH11 = 3;
	localparam int PIG_BIT_CH10 = 2;
	localparam int PIG_BIT_CH6_7 = 1;
	localparam int PIG_BIT_CH8_9 = 0;
	localparam int PIG_BIT_REMAP = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] PIG_RST_REG16 = 16'h0000;
	localparam logic [31:0] PIG_RST_WORD = 32'h0000_0000;

	// Per-port interrupt configuration
	typedef struct packed {
		logic [15:0] enable;
		logic [15:0] edge_mode;
	} pig_irq_cfg_s;

endpackage

// ---- pig_port_cfg_sva.sv ----
// Purpose: Port-level checks of the pin gate and interrupt block
// Assumes: Only top-level ports are visible
// Notes: Register contents are checked by the bench
`timescale 1ns/10ps
module pig_port_cfg_sva (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] pa_pin_in,
	input wire logic [15:0] pa_dir_out,
	input wire logic [23:0] pb_dir_out,
	input wire logic usb1_ctrl_pullup_enable,
	input wire logic usb2_ctrl_pullup_enable,
	input wire logic [15:0] pa_din,
	input wire logic usb1_dplus_pullup,
	input wire logic usb2_dplus_pullup,
	input wire logic pa_irq_req,
	input wire logic pb_irq_req
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// ****************************************
	// Bus and pin checks
	// ****************************************
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready && psel && penable;
	endsequence
	a_setup_answer: assert property (s_setup |=> s_answer)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_din_gated: assert property ((pa_din & ~$past(pa_pin_in)) == 16'h0000)
		else $error("input high without pin");
	a_pullup_one: assert property ($past(usb1_ctrl_pullup_enable) && $past(!reset, 2) |-> usb1_dplus_pullup)
		else $error("first pull-up off");
	a_pullup_two: assert property ($past(usb2_ctrl_pullup_enable) && $past(!reset, 2) |-> usb2_dplus_pullup)
		else $error("second pull-up off");
	a_irq_dir_a: assert property ($rose(pa_irq_req) |-> $past(pa_dir_out, 2) != 16'hffff)
		else $error("port a request from outputs");
	a_irq_dir_b: assert property ($rose(pb_irq_req) |-> $past(pb_dir_out, 2) != 24'hffffff)
		else $error("port b request from outputs");
endmodule

// ---- pig_pin_model.sv ----
// Purpose: Outside world driving port A and B pin levels
// Assumes: Levels are synchronous to ref_clk
// Notes: One register stage stands in for the pad path
`timescale 1ns/10ps
module pig_pin_model (
	input wire logic ref_clk,
	input wire logic [15:0] pa_lvl,
	input wire logic [23:0] pb_lvl,
	output logic [15:0] pa_pin_in,
	output logic [23:0] pb_pin_in
);
	always_ff @(posedge ref_clk) begin
		pa_pin_in <= pa_lvl;
		pb_pin_in <= pb_lvl;
	end
endmodule

// ---- pig_port_cfg_tb_top.sv ----
// Purpose: Self-checking bench of the pin gate and interrupt block
// Assumes: Pin levels reach the block through the pin model
// Notes: Register model in the bench gives the expectation of every rchk read; pending flag reads in the trigger loop use computed values
`timescale 1ns/10ps
module pig_port_cfg_tb_top;
	logic ref_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, c1 = 1'h0, c2 = 1'h0, p, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, claim1, claim2, pu1, pu2, pa_irq_req, pb_irq_req;
	logic [15:0] pa_pin_in, pa_din, pa_lvl = 16'h0, pa_od = 16'h0, pa_dir = 16'h0;
	logic [23:0] pb_pin_in, pb_lvl = 24'h0, pb_od = 24'h0, pb_dir = 24'h0;
	logic [15:0] gm[16] = '{16'h0003, 16'h000c, 16'h0040, 16'h0080, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h0010, 16'h0020, 16'h0100, 16'h0200, 16'h0c00, 16'h3000, 16'hc000};
	logic [7:0] ofs[5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
	int slot[6] = '{3, 15, 5, 8, 9, 0};
	int pin[6] = '{3, 15, 5, 22, 9, 0};
	int edg[6] = '{0, 1, 0, 1, 0, 0};
	int en[6] = '{1, 1, 0, 1, 1, 1};
	int fail_count = 0, checked = 0, seed = 80, mdl[9];
	logic [7:0] pr;
	always #2.5 ref_clk = ~ref_clk;
	pig_port_cfg u_pig_port_cfg (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pa_pin_in, .pb_pin_in, .pa_out_data(pa_od), .pb_out_data(pb_od), .pa_dir_out(pa_dir),
		.pb_dir_out(pb_dir), .usb1_ctrl_pullup_enable(c1), .usb2_ctrl_pullup_enable(c2), .pa_din,
		.first_usb_pin_claim(claim1), .second_usb_pin_claim(claim2), .usb1_dplus_pullup(pu1),
		.usb2_dplus_pullup(pu2), .pa_irq_req, .pb_irq_req);
	pig_pin_model u_pig_pin_model (.ref_clk, .pa_lvl, .pb_lvl, .pa_pin_in, .pb_pin_in);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		if (a < 8'h14 || a == 8'h1c) mdl[a >> 2] = d & (a == 8'h1c ? 32'h1 : 32'hffff);
	endtask
	task automatic rchk(input logic [7:0] a);
		apb(1'h0, a, 32'h0);
		chk(rd, mdl[a >> 2]);
		chk(er, a > 8'h1c);
	endtask
	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'h0;
		for (int k = 0; k < 9; k++) rchk(8'(k * 4)); // Reset values and unmapped
		foreach (ofs[k]) begin
			wr(ofs[k], $random(seed));
			rchk(ofs[k]); // Readback
		end
		for (int b = 0; b < 16; b++) begin
			@(posedge ref_clk);
			pa_lvl <= 16'($random(seed));
			c1 <= 1'($random(seed));
			c2 <= 1'($random(seed));
			wr(8'h00, 32'h1 << b);
			rchk(8'h00);
			@(negedge ref_clk);
			chk({pa_din, claim1, claim2, pu1, pu2}, {pa_lvl & ~gm[b], b == 7, b == 5, b == 6 || c1, b == 4 || c2}); // Gate to
		end
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			p = 1'($random(seed));
			pa_od <= {16{p}};
			pb_od <= {24{p}};
			pa_lvl <= {16{~p}};
			pb_lvl <= {24{~p}};
			pr = (i == 3 || i == 4) ? 8'h08 : 8'h04;
			// Quiet both ports before arming one slot
			wr(8'h04, 32'h0);
			wr(8'h08, 32'h0);
			wr(8'h14, 32'hffff);
			wr(8'h18, 32'hffff);
			wr(8'h1c, 32'(pin[i] > 15));
			wr(8'h00, 32'(i == 5));
			wr(pr, 32'(en[i]) << slot[i]);
			wr(pr + 8'h08, 32'(edg[i]) << slot[i]);
			wr(pr + 8'h10, 32'hffff);
			if (pr == 8'h08) pb_lvl[pin[i]] <= p;
			else pa_lvl[pin[i]] <= p;
			repeat (4) @(negedge ref_clk);
			chk(pr == 8'h08 ? pb_irq_req : pa_irq_req, en[i] && i != 5); // Request
			apb(1'h0, pr + 8'h10, 32'h0);
			chk(rd, 32'(en[i] && i != 5) << slot[i]); // Flag
			if (edg[i] == 0) begin
				pa_lvl <= {16{~p}};
				pb_lvl <= {24{~p}};
			end
			wr(pr + 8'h10, 32'h1 << slot[i]);
			apb(1'h0, pr + 8'h10, 32'h0);
			@(negedge ref_clk);
			chk({rd, pa_irq_req, pb_irq_req}, 34'h0); // Clear and no retrigger
		end
		give_verdict();
	end
endmodule
bind pig_port_cfg pig_port_cfg_sva u_pig_port_cfg_sva (.ref_clk, .reset, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .pa_pin_in, .pa_dir_out, .pb_dir_out, .usb1_ctrl_pullup_enable, .usb2_ctrl_pullup_enable, .pa_din,
	.usb1_dplus_pullup, .usb2_dplus_pullup, .pa_irq_req, .pb_irq_req);
